/* File: verilog/sfc_map.vh */
// Opcodes, status bit positions, reset values and timing counts of the flash command interpreter.
// How it works
// - Write-enable opcode sets the write latch flag to one.
// - Volatile write-enable leaves the latch unchanged and arms volatile status writes.
// - Write-disable opcode, framed by chip select, clears the write latch.
// - Latch clears at power-up, reset and completion of a status write cycle.
// - Read-status opcode picks register one, two or three; bits go out MSB first.
// - Read-status works at any time and repeats until chip select rises.
// - Status writes change only writable fields; other bits are read-only.
// - Once an OTP lock bit is one it never returns to zero.
// - Non-volatile status write needs the latch set by a prior write-enable.
// - Volatile write changes volatile copies only; lockdown and lock bits never clear.
// - Reset discards volatile status and reloads the non-volatile copies.
// - Non-volatile write runs a timed busy cycle, then clears the latch.
// - Volatile write applies within the refresh time with busy held at zero.
// - Sixteen data bits after opcode one write registers one and two.
// - Eight data bits after opcode one write register one alone.
// - Plain read latches opcode and 24-bit address, then streams the byte MSB first.
// - Plain read increments the address after each byte until chip select rises.
// - Plain read while busy is ignored and leaves the running cycle alone.
// - Plain read is recognised only in single-line mode.
// - Wrap byte takes the wrap-disable bit and length from lines zero to two on clock seven.
// - Wrap disable bit is one after reset; codes select 8 to 64 byte sections.
`ifndef SFC_MAP_VH
`define SFC_MAP_VH
`define SFC_OP_WREN     8'h06
`define SFC_OP_VWREN    8'h50
`define SFC_OP_WRDI     8'h04
`define SFC_OP_RDSR1    8'h05
`define SFC_OP_RDSR2    8'h35
`define SFC_OP_RDSR3    8'h15
`define SFC_OP_WRSR1    8'h01
`define SFC_OP_WRSR2    8'h31
`define SFC_OP_WRSR3    8'h11
`define SFC_OP_READ     8'h03
`define SFC_OP_WRAP     8'h77
`define SFC_SR1_WMASK   8'h7C
`define SFC_SR2_WMASK   8'h7B
`define SFC_SR3_WMASK   8'h64
`define SFC_SR2_LOCKS   8'h39
`define SFC_SR1_BUSY    0
`define SFC_SR1_WLATCH  1
`define SFC_SR_RESET    8'h00
`define SFC_WRAP_BIT    4
`define SFC_WRAP_CLK    6
`define SFC_WRAP_DONE   8
`define SFC_ADDR_BITS   24
`define SFC_WRITE_US    10
`define SFC_TREF_NS     50
`define SFC_CLK_MHZ     125
`endif

/* File: verilog/sfc_edge.v */
// Pin synchroniser with rising and falling edge detection of the serial clock.
module sfc_edge
(
  input  wire clk_in,
  input  wire rst_n_in,
  input  wire pin_in,
  output wire level_out,
  output wire rise_out,
  output wire fall_out
);
  reg meta;
  reg sync;
  reg prev;
  always @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      meta <= 1'b0;
      sync <= 1'b0;
      prev <= 1'b0;
    end
    else
    begin
      meta <= pin_in;
      sync <= meta;
      prev <= sync;
    end
  end
  assign level_out = sync;
  assign rise_out  = sync & ~prev;
  assign fall_out  = ~sync & prev;
endmodule // sfc_edge

/* File: verilog/sfc_top.v */
// Command interpreter of the serial flash: status, write-enable, wrap and plain read commands.
`include "sfc_map.vh"
module sfc_top
#(
  parameter WRITE_TIME_CYCLES = `SFC_WRITE_US * `SFC_CLK_MHZ,
  parameter TREF_CYCLES       = (`SFC_TREF_NS * `SFC_CLK_MHZ) / 1000,
  parameter MEM_AW            = 8
)
(
  input  wire                     CLOCK_IN,
  input  wire                     RESETN_IN,
  input  wire                     CS_N_IN,
  input  wire                     SCK_IN,
  input  wire [3:0]               IO_IN,
  output reg                      DO_OUT,
  output wire                     DO_OE_OUT,
  input  wire                     QUAD_MODE_IN,
  input  wire                     EXT_BUSY_IN,
  output reg  [MEM_AW-1:0]        MEM_ADDR_OUT,
  input  wire [7:0]               MEM_DATA_IN,
  input  wire [7:0]               NV_SR1_IN,
  input  wire [7:0]               NV_SR2_IN,
  input  wire [7:0]               NV_SR3_IN,
  output reg  [7:0]               NV_SR1_OUT,
  output reg  [7:0]               NV_SR2_OUT,
  output reg  [7:0]               NV_SR3_OUT,
  output reg                      NV_WRITE_OUT,
  output wire                     BUSY_OUT,
  output wire                     WRITE_LATCH_FLAG_OUT,
  output reg                      WRAP_DISABLE_BIT_OUT,
  output reg  [1:0]               WRAP_LENGTH_OUT
);
  // ****************************************************************
  // Synchronisers
  // ****************************************************************
  wire cs_sel;
  wire cs_n = ~cs_sel;
  wire sck_rise;
  wire sck_fall;
  reg  [3:0] io_m;
  reg  [3:0] io_s;
  reg        cs_prev;
  sfc_edge u_sck
  (
    .clk_in    (CLOCK_IN),
    .rst_n_in  (RESETN_IN),
    .pin_in    (SCK_IN),
    .level_out (),
    .rise_out  (sck_rise),
    .fall_out  (sck_fall)
  );
  sfc_edge u_cs
  (
    .clk_in    (CLOCK_IN),
    .rst_n_in  (RESETN_IN),
    // Inverted in so that the synchroniser's reset value reads as deselected.
    .pin_in    (~CS_N_IN),
    .level_out (cs_sel),
    .rise_out  (),
    .fall_out  ()
  );
  always @(posedge CLOCK_IN)
  begin
    if (!RESETN_IN)
    begin
      io_m    <= 4'h0;
      io_s    <= 4'h0;
      cs_prev <= 1'b1;
    end
    else
    begin
      io_m    <= IO_IN;
      io_s    <= io_m;
      cs_prev <= cs_n;
    end
  end
  wire cs_end = cs_n & ~cs_prev;
  wire active = ~cs_n;

  // ****************************************************************
  // Frame state
  // ****************************************************************
  localparam ST_OPC  = 6'b000001;
  localparam ST_RDSR = 6'b000010;
  localparam ST_WRSR = 6'b000100;
  localparam ST_ADDR = 6'b001000;
  localparam ST_DATA = 6'b010000;
  localparam ST_SKIP = 6'b100000;

  reg  [5:0]  state;
  reg  [7:0]  shift;
  reg  [5:0]  bits;
  reg  [7:0]  opcode;
  reg  [7:0]  out_byte;
  reg  [2:0]  out_cnt;
  reg  [23:0] addr;
  reg  [7:0]  sr1;
  reg  [7:0]  sr2;
  reg  [7:0]  sr3;
  reg  [7:0]  wr_b1;
  reg  [7:0]  wr_b2;
  reg         write_latch_flag;
  reg         vol_arm;
  reg         nv_busy;
  reg  [31:0] timer;
  reg         opc_seen;
  reg         ref_pend;
  reg  [31:0] ref_timer;

  wire [7:0] in_byte = {shift[6:0], io_s[0]};
  wire       busy    = nv_busy | EXT_BUSY_IN;
  assign BUSY_OUT             = busy;
  assign WRITE_LATCH_FLAG_OUT = write_latch_flag;
  assign DO_OE_OUT            = active & ((state == ST_RDSR) | (state == ST_DATA));

  function [7:0] status_view;
    input [1:0] sel;
    input [7:0] r1;
    input [7:0] r2;
    input [7:0] r3;
    input       b;
    input       w;
    begin
      case (sel)
        2'd0:    status_view = (r1 & `SFC_SR1_WMASK) | {6'h00, w, b};
        2'd1:    status_view = r2;
        default: status_view = r3;
      endcase
    end
  endfunction

  // A write keeps read-only bits, and lock bits may only be raised.
  function [7:0] merge;
    input [7:0] old;
    input [7:0] data;
    input [7:0] wmask;
    input [7:0] lmask;
    begin
      merge = ((old & ~wmask) | (data & wmask)) | (old & lmask);
    end
  endfunction

  reg [1:0] rd_sel;
  always @*
  begin
    case (opcode)
      `SFC_OP_RDSR2: rd_sel = 2'd1;
      `SFC_OP_RDSR3: rd_sel = 2'd2;
      default:       rd_sel = 2'd0;
    endcase
  end
  wire [7:0] status_byte = status_view(rd_sel, sr1, sr2, sr3, busy, write_latch_flag);

  // ****************************************************************
  // Command engine
  // ****************************************************************
  always @(posedge CLOCK_IN)
  begin
    if (!RESETN_IN)
    begin
      state    <= ST_OPC;
      shift    <= 8'h00;
      bits     <= 6'd0;
      opcode   <= 8'h00;
      out_byte <= 8'h00;
      out_cnt  <= 3'd0;
      addr     <= 24'h000000;
      DO_OUT   <= 1'b0;
      MEM_ADDR_OUT <= {MEM_AW{1'b0}};
      sr1      <= `SFC_SR_RESET;
      sr2      <= `SFC_SR_RESET;
      sr3      <= `SFC_SR_RESET;
      wr_b1    <= 8'h00;
      wr_b2    <= 8'h00;
      write_latch_flag <= 1'b0;
      vol_arm  <= 1'b0;
      nv_busy  <= 1'b0;
      timer    <= 32'd0;
      opc_seen <= 1'b0;
      ref_pend <= 1'b0;
      ref_timer <= 32'd0;
      NV_SR1_OUT <= `SFC_SR_RESET;
      NV_SR2_OUT <= `SFC_SR_RESET;
      NV_SR3_OUT <= `SFC_SR_RESET;
      NV_WRITE_OUT <= 1'b0;
      WRAP_DISABLE_BIT_OUT <= 1'b1;
      WRAP_LENGTH_OUT <= 2'b00;
    end
    else
    begin
      NV_WRITE_OUT <= 1'b0;
      // Volatile values are reloaded from the stored copies one cycle after reset.
      if (!opc_seen)
      begin
        opc_seen <= 1'b1;
        sr1 <= NV_SR1_IN & `SFC_SR1_WMASK;
        sr2 <= NV_SR2_IN;
        sr3 <= NV_SR3_IN;
      end
      if (nv_busy)
      begin
        if (timer == 32'd1)
        begin
          nv_busy <= 1'b0;
          write_latch_flag <= 1'b0;
          NV_WRITE_OUT <= 1'b1;
          NV_SR1_OUT <= sr1;
          NV_SR2_OUT <= sr2;
          NV_SR3_OUT <= sr3;
        end
        timer <= timer - 32'd1;
      end
      if (ref_pend)
      begin
        ref_timer <= ref_timer - 32'd1;
        if (ref_timer <= 32'd1)
          ref_pend <= 1'b0;
      end
      if (cs_end)
      begin
        // Commands act only on a frame with a full opcode.
        if (bits >= 6'd8 && state == ST_OPC)
        begin
          case (opcode)
            `SFC_OP_WREN:  write_latch_flag <= 1'b1;
            `SFC_OP_VWREN: vol_arm          <= 1'b1;
            `SFC_OP_WRDI:  write_latch_flag <= 1'b0;
            default:       vol_arm <= vol_arm;
          endcase
        end
        if (state == ST_WRSR && bits >= 6'd16 && !nv_busy && (write_latch_flag | vol_arm))
        begin
          case (opcode)
            `SFC_OP_WRSR1:
            begin
              sr1 <= merge(sr1, wr_b1, `SFC_SR1_WMASK, 8'h00);
              if (bits >= 6'd24)
                sr2 <= merge(sr2, wr_b2, `SFC_SR2_WMASK, `SFC_SR2_LOCKS);
              // Eight data bits leave register two untouched.
            end
            `SFC_OP_WRSR2: sr2 <= merge(sr2, wr_b1, `SFC_SR2_WMASK, `SFC_SR2_LOCKS);
            default:       sr3 <= merge(sr3, wr_b1, `SFC_SR3_WMASK, 8'h00);
          endcase
          if (write_latch_flag && !vol_arm)
          begin
            nv_busy <= 1'b1;
            timer   <= WRITE_TIME_CYCLES;
          end
          else
          begin
            ref_pend  <= 1'b1;
            ref_timer <= TREF_CYCLES;
            vol_arm   <= 1'b0;
          end
        end
        if (state == ST_WRSR || (bits >= 6'd8 && opcode != `SFC_OP_VWREN))
          vol_arm <= 1'b0;
        state <= ST_OPC;
        bits  <= 6'd0;
      end
      else if (active && sck_rise)
      begin
        shift <= in_byte;
        bits  <= (bits == 6'd63) ? bits : bits + 6'd1;
        case (state)
          ST_OPC:
          begin
            if (bits == 6'd7)
            begin
              opcode <= in_byte;
              case (in_byte)
                `SFC_OP_RDSR1, `SFC_OP_RDSR2, `SFC_OP_RDSR3:
                  state <= ST_RDSR;
                `SFC_OP_WRSR1, `SFC_OP_WRSR2, `SFC_OP_WRSR3:
                  state <= ST_WRSR;
                `SFC_OP_READ:
                  state <= (busy || QUAD_MODE_IN) ? ST_SKIP : ST_ADDR;
                `SFC_OP_WRAP:
                  state <= ST_SKIP;
                default:
                  state <= ST_OPC;
              endcase
            end
          end
          ST_WRSR:
          begin
            if (bits == 6'd15)
              wr_b1 <= in_byte;
            if (bits == 6'd23)
              wr_b2 <= in_byte;
          end
          ST_ADDR:
          begin
            addr <= {addr[22:0], io_s[0]};
            if (bits == 6'd31)
            begin
              state <= ST_DATA;
              MEM_ADDR_OUT <= {addr[MEM_AW-2:0], io_s[0]};
            end
          end
          ST_SKIP:
          begin
            // Only the seventh four-line clock after the opcode counts; others are ignored.
            if (opcode == `SFC_OP_WRAP && bits == (6'd8 + `SFC_WRAP_CLK))
            begin
              WRAP_DISABLE_BIT_OUT <= io_s[0];
              WRAP_LENGTH_OUT <= io_s[2:1];
            end
          end
          default:
            state <= state;
        endcase
      end
      if (active && sck_fall && (state == ST_RDSR || state == ST_DATA))
      begin
        // Bits leave MSB first; a new byte loads each time the count wraps.
        if (out_cnt == 3'd0)
        begin
          if (state == ST_RDSR)
          begin
            DO_OUT   <= status_byte[7];
            out_byte <= status_byte << 1;
          end
          else
          begin
            DO_OUT   <= MEM_DATA_IN[7];
            out_byte <= MEM_DATA_IN << 1;
            MEM_ADDR_OUT <= MEM_ADDR_OUT + {{(MEM_AW-1){1'b0}}, 1'b1};
          end
        end
        else
        begin
          DO_OUT   <= out_byte[7];
          out_byte <= out_byte << 1;
        end
        out_cnt <= out_cnt + 3'd1;
      end
      if (cs_end)
        out_cnt <= 3'd0;
    end
  end
endmodule // sfc_top

/* File: dv/sfc_props.sv */
// Concurrent port checks of the flash command interpreter.
`include "sfc_map.vh"
module sfc_checker
#(
  parameter WRITE_TIME_CYCLES = 1250
)
(
  input wire logic       CLOCK_IN,
  input wire logic       RESETN_IN,
  input wire logic       CS_N_IN,
  input wire logic       EXT_BUSY_IN,
  input wire logic       DO_OE_OUT,
  input wire logic [7:0] NV_SR2_IN,
  input wire logic [7:0] NV_SR3_IN,
  input wire logic [7:0] NV_SR2_OUT,
  input wire logic [7:0] NV_SR3_OUT,
  input wire logic       NV_WRITE_OUT,
  input wire logic       BUSY_OUT,
  input wire logic       WRITE_LATCH_FLAG_OUT
);
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (!RESETN_IN);
  // The length is held after busy drops, since the store pulse may trail it.
  int   busy_len;
  logic busy_q;
  always @(posedge CLOCK_IN)
  begin
    busy_q <= BUSY_OUT;
    if (!RESETN_IN)
      busy_len <= 0;
    else if (BUSY_OUT)
      busy_len <= busy_q ? busy_len + 1 : 1;
  end
  a_oe_idle: assert property (CS_N_IN [*4] |-> !DO_OE_OUT)
    else $error("Data out enabled outside a frame.");
  a_latch_framed: assert property ($rose(WRITE_LATCH_FLAG_OUT) |-> CS_N_IN)
    else $error("Write latch set inside a frame.");
  a_latch_after_nv: assert property (NV_WRITE_OUT |-> ##[0:2] !WRITE_LATCH_FLAG_OUT)
    else $error("Write latch kept after status write.");
  a_nv_pulse: assert property (NV_WRITE_OUT |=> !NV_WRITE_OUT)
    else $error("Store pulse longer than one cycle.");
  a_lock_sticky: assert property (NV_WRITE_OUT |->
    ((NV_SR2_OUT & NV_SR2_IN & `SFC_SR2_LOCKS) == (NV_SR2_IN & `SFC_SR2_LOCKS)))
    else $error("Lock bit cleared.");
  a_ro_bits: assert property (NV_WRITE_OUT |->
    ((NV_SR3_OUT & ~`SFC_SR3_WMASK) == (NV_SR3_IN & ~`SFC_SR3_WMASK)))
    else $error("Read-only status bit changed.");
  a_busy_len: assert property (NV_WRITE_OUT |->
    (busy_len >= WRITE_TIME_CYCLES - 2 && busy_len <= WRITE_TIME_CYCLES + 2))
    else $error("Write cycle length wrong.");
  a_busy_start: assert property ($rose(BUSY_OUT) && !EXT_BUSY_IN |-> CS_N_IN)
    else $error("Write cycle began inside a frame.");
  a_ext_busy: assert property (EXT_BUSY_IN |-> ##[0:1] BUSY_OUT)
    else $error("Outside busy not reported.");
  c_nv_write: cover property (NV_WRITE_OUT);
  c_data_out: cover property (DO_OE_OUT);
  c_wel_set: cover property ($rose(WRITE_LATCH_FLAG_OUT));
endmodule // sfc_checker

/* File: dv/sfc_host.sv */
// Host controller model: frames, serial clock, data lines and memory bytes equal to the address XOR 5A.
module sfc_host
(
  input  wire logic       clk_in,
  input  wire logic       do_in,
  input  wire logic       oe_in,
  input  wire logic [7:0] addr_in,
  output logic            cs_n_out,
  output logic            sck_out,
  output logic [3:0]      io_out,
  output logic [7:0]      data_out
);
  timeunit 1ns;
  timeprecision 1ns;
  assign data_out = addr_in ^ 8'h5A;
  initial
  begin
    cs_n_out = 1'b1;
    sck_out  = 1'b0;
    io_out   = 4'h0;
  end
  // Clock stands low between frames; released lines show the inverse.
  task xfer(input int n, input logic [63:0] tx, input logic [2:0] hi,
            output logic [63:0] rx, output logic oe);
    rx = '0;
    oe = 1'b0;
    @(negedge clk_in);
    cs_n_out = 1'b0;
    for (int i = n - 1; i >= 0; i--)
    begin
      io_out = {hi, tx[i]};
      #32;
      sck_out = 1'b1;
      rx = {rx[62:0], do_in};
      oe = oe | oe_in;
      #32;
      sck_out = 1'b0;
    end
    #32;
    cs_n_out = 1'b1;
    io_out = ~io_out;
    #128;
  endtask
endmodule // sfc_host

/* File: dv/sfc_top_bench.sv */
// Self-checking bench of the flash command interpreter.
module sfc_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int WR_CYC = 2000;
  logic        clk = 0, rstn = 0, quad = 0, xbusy = 0, roe;
  logic        cs_n, sck, do_w, oe, nvw, busy, wlatch, wdis;
  logic [3:0]  io;
  logic [1:0]  wlen;
  logic [7:0]  maddr, mdata, s1o, s2o, s3o, s1 = 8'h04, s2 = 8'h02, s3 = 8'h00;
  logic [63:0] rx;
  int          error_cnt = 0, n_checks = 0;
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("ERROR %0t: got %h want %h", $time, g, e); end end
  always #4 clk = ~clk;
  // Stored status copies follow the store pulse like the array would.
  always @(posedge clk)
    if (nvw)
    begin
      s1 <= s1o;
      s2 <= s2o;
      s3 <= s3o;
    end
  sfc_top #(.WRITE_TIME_CYCLES(WR_CYC)) i_dut (.CLOCK_IN(clk), .RESETN_IN(rstn), .CS_N_IN(cs_n),
    .SCK_IN(sck), .IO_IN(io), .DO_OUT(do_w), .DO_OE_OUT(oe), .QUAD_MODE_IN(quad),
    .EXT_BUSY_IN(xbusy), .MEM_ADDR_OUT(maddr), .MEM_DATA_IN(mdata), .NV_SR1_IN(s1),
    .NV_SR2_IN(s2), .NV_SR3_IN(s3), .NV_SR1_OUT(s1o), .NV_SR2_OUT(s2o),
    .NV_SR3_OUT(s3o), .NV_WRITE_OUT(nvw), .BUSY_OUT(busy),
    .WRITE_LATCH_FLAG_OUT(wlatch), .WRAP_DISABLE_BIT_OUT(wdis), .WRAP_LENGTH_OUT(wlen));
  sfc_host i_host (.clk_in(clk), .do_in(do_w), .oe_in(oe), .addr_in(maddr),
    .cs_n_out(cs_n), .sck_out(sck), .io_out(io), .data_out(mdata));
  task cmd(input int n, input logic [63:0] tx);
    i_host.xfer(n, tx, 3'b111, rx, roe);
  endtask
  task rdsr(input logic [7:0] op, input logic [7:0] e);
    cmd(24, {op, 16'h0});
    `CHK(rx[15:0], {e, e})
  endtask
  task do_reset;
    @(negedge clk);
    rstn = 1'b0;
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    repeat (6) @(negedge clk);
  endtask
  task final_report;
    $display("Checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial
  begin
    do_reset();
    `CHK(wlatch, 1'b0)
    `CHK(wdis, 1'b1)
    rdsr(8'h35, 8'h02);
    cmd(8, 64'h06);
    `CHK(wlatch, 1'b1)
    rdsr(8'h05, 8'h06);
    cmd(5, 64'h00);
    `CHK(wlatch, 1'b1)
    cmd(8, 64'h04);
    `CHK(wlatch, 1'b0)
    cmd(16, 64'h01FF);
    rdsr(8'h05, 8'h04);
    cmd(8, 64'h50);
    `CHK(wlatch, 1'b0)
    cmd(16, 64'h0100);
    `CHK(busy, 1'b0)
    rdsr(8'h05, 8'h00);
    rdsr(8'h35, 8'h02);
    cmd(8, 64'h06);
    cmd(24, 64'h01FFFF);
    `CHK(busy, 1'b1)
    rdsr(8'h05, 8'h7F);
    cmd(48, {8'h03, 24'h10, 16'h0});
    `CHK(roe, 1'b0)
    for (int i = 0; i < 4000 && busy !== 1'b0; i++) @(negedge clk);
    // The stored copies take the store pulse one edge after busy drops.
    repeat (2) @(negedge clk);
    `CHK(busy, 1'b0)
    `CHK(wlatch, 1'b0)
    `CHK({s1, s2}, 16'h7C7B)
    cmd(8, 64'h50);
    cmd(16, 64'h3100);
    rdsr(8'h35, 8'h39);
    do_reset();
    rdsr(8'h35, 8'h7B);
    rdsr(8'h15, 8'h00);
    cmd(48, {8'h03, 24'h10, 16'h0});
    `CHK({roe, rx[15:0]}, 17'h14A4B)
    quad = 1'b1;
    cmd(48, {8'h03, 24'h10, 16'h0});
    `CHK(roe, 1'b0)
    quad = 1'b0;
    xbusy = 1'b1;
    cmd(48, {8'h03, 24'h10, 16'h0});
    `CHK(roe, 1'b0)
    xbusy = 1'b0;
    for (int c = 0; c < 5; c++)
    begin
      i_host.xfer(16, {8'h77, 6'h00, c[2], 1'b0}, {1'b0, c[1:0]}, rx, roe);
      `CHK({wdis, wlen}, c[2:0])
    end
    final_report();
  end
  initial
  begin
    #400000;
    error_cnt++;
    final_report();
  end
endmodule // sfc_top_bench
bind sfc_top sfc_checker #(.WRITE_TIME_CYCLES(WRITE_TIME_CYCLES)) u_chk (.CLOCK_IN(CLOCK_IN),
  .RESETN_IN(RESETN_IN), .CS_N_IN(CS_N_IN), .EXT_BUSY_IN(EXT_BUSY_IN),
  .DO_OE_OUT(DO_OE_OUT), .NV_SR2_IN(NV_SR2_IN), .NV_SR3_IN(NV_SR3_IN),
  .NV_SR2_OUT(NV_SR2_OUT), .NV_SR3_OUT(NV_SR3_OUT), .NV_WRITE_OUT(NV_WRITE_OUT),
  .BUSY_OUT(BUSY_OUT), .WRITE_LATCH_FLAG_OUT(WRITE_LATCH_FLAG_OUT));
